// >>> tb/disk_seek_verify_param_cmds_tb.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: host strobes driven at the falling edge, read data valid a cycle later
// Notes: geometry and seek targets are predicted by integer arithmetic here
`timescale 1ns/10ps
`include "disk_cmd_consts.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module disk_seek_verify_param_cmds_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, slow = 0, dval = 0;
  logic [9:0] addr = 0;
  logic [7:0] wd = 0, rdat, fail_at = 0, nver, spt;
  logic [15:0] cyl;
  logic [3:0] head, mh;
  logic intrq, drq, mw, mv, ms, done, err;
  logic [7:0] gspt = 8'h3f;
  logic [3:0] gmh = 4'hf;
  logic [31:0] seed = 32'd49545;
  int n_mismatch = 0, comparisons = 0;
  disk_seek_verify_param_cmds i_disk_seek_verify_param_cmds(.i_ref_clk(clk), .i_rst(rst),
    .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdat), .o_intrq(intrq),
    .o_drq(drq), .o_media_write(mw), .o_media_verify(mv), .o_media_seek(ms),
    .o_seek_cyl(cyl), .o_seek_head(head), .o_geom_spt(spt), .o_geom_maxhead(mh),
    .i_media_done(done), .i_media_err(err), .i_data_valid(dval));
  media_model i_media_model(.i_ref_clk(clk), .i_rst(rst), .i_write(mw), .i_verify(mv),
    .i_seek(ms), .i_slow(slow), .i_fail_at(fail_at), .o_done(done), .o_err(err),
    .o_nverify(nver));
  initial
  begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task rd_reg(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdat;
  endtask
  task issue(input logic [7:0] sc, sn, cl, ch, dh, op);
    wr_reg(`ADDR_SECTOR_COUNT, sc);
    wr_reg(`ADDR_SECTOR_NUMBER, sn);
    wr_reg(`ADDR_CYLINDER_LOW, cl);
    wr_reg(`ADDR_CYLINDER_HIGH, ch);
    wr_reg(`ADDR_DEVICE_HEAD, dh);
    wr_reg(`ADDR_COMMAND_STATUS, op);
  endtask
  // bounded wait for an interrupt or a data request
  task wait_for(input bit want_drq);
    int k;
    for (k = 0; k < 2000 && intrq !== 1'b1 && !(want_drq && drq === 1'b1); k++)
      @(negedge clk);
    if (k == 2000)
    begin
      n_mismatch++;
      $display("[ERR] wait exp 1 got 0");
      give_verdict;
    end
  endtask
  task finish_cmd(input logic [7:0] est, output logic [7:0] s);
    wait_for(0);
    rd_reg(`ADDR_COMMAND_STATUS, s);
  endtask
  task wv(input int n, input int bad);
    logic [7:0] s, base;
    int k;
    base = nver;
    fail_at = bad ? nver + 8'(bad) : 8'h00;
    issue(8'(n), 8'h01, 8'h00, 8'h00, 8'h00, `OP_WRITE_VERIFY);
    for (k = 0; k < n && intrq !== 1'b1; k++)
    begin
      wait_for(1);
      if (drq === 1'b1)
      begin
        dval = 1;
        @(negedge clk);
        dval = 0;
      end
    end
    finish_cmd(8'h50, s);
    `CHK("wv status", bad ? 8'h51 : 8'h50, s)
    `CHK("verifies", 8'(bad ? bad : n), 8'(nver - base))
    rd_reg(`ADDR_SECTOR_COUNT, s);
    `CHK("wv sc", 8'(bad ? n - bad + 1 : 0), s)
  endtask
  initial
  begin
    logic [7:0] s, v;
    logic [31:0] r;
    int i, lba, trk;
    repeat (12) @(negedge clk);
    rst = 0;
    rd_reg(`ADDR_COMMAND_STATUS, s);
    `CHK("status", 8'h50, s)
    rd_reg(10'h1f0, s);
    `CHK("unmapped", 8'h00, s)
    $display("test reset done");
    // second pass sets the addressing-mode bit, which must change nothing
    for (i = 0; i < 2; i++)
    begin
      r = rnd();
      gspt = 8'(r[7:0] % 255 + 1);
      gmh = r[11:8];
      issue(gspt, 8'h00, 8'h00, 8'h00, {1'b0, i[0], 2'b00, gmh}, `OP_SET_GEOMETRY);
      finish_cmd(8'h50, s);
      `CHK("geom status", 8'h50, s)
      `CHK("spt", gspt, spt)
      `CHK("maxhead", gmh, mh)
    end
    issue(8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, `OP_SET_GEOMETRY);
    finish_cmd(8'h51, s);
    `CHK("abort status", 8'h51, s)
    rd_reg(`ADDR_FEATURES_ERROR, s);
    `CHK("abort error", 8'h04, s)
    issue(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    finish_cmd(8'h51, s);
    `CHK("unknown op status", 8'h51, s)
    rd_reg(`ADDR_FEATURES_ERROR, s);
    `CHK("unknown op error", 8'h04, s)
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    `CHK("kept spt", gspt, spt)
    `CHK("kept maxhead", gmh, mh)
    $display("test geometry done");
    for (i = 8'h10; i < 8'h20; i++)
    begin
      slow = i[0];
      r = rnd();
      issue(8'h01, 8'h01, r[7:0], r[15:8], {1'b0, i[1], 6'h00}, 8'(i));
      if (slow)
      begin
        rd_reg(`ADDR_COMMAND_STATUS, s);
        `CHK("recal busy", 1'b1, s[7])
      end
      finish_cmd(8'h50, s);
      `CHK("recal status", 8'h50, s)
      `CHK("recal cyl", 16'h0000, cyl)
    end
    $display("test recalibrate done");
    for (i = 8'h70; i < 8'h80; i++)
    begin
      slow = i[1];
      r = rnd();
      issue(8'h01, r[7:0], r[15:8], r[23:16], {1'b0, i[0], 2'b00, r[27:24]}, 8'(i));
      finish_cmd(8'h50, s);
      `CHK("seek status", 8'h50, s)
      lba = int'(r[27:0]);
      trk = lba / int'(gspt);
      `CHK("seek cyl", i[0] ? 16'(trk / (gmh + 1)) : r[23:8], cyl)
      `CHK("seek head", i[0] ? 4'(trk % (gmh + 1)) : r[27:24], head)
    end
    $display("test seek done");
    slow = 0;
    wv(3, 0);
    slow = 1;
    wv(4, 2);
    wv(1, 1);
    $display("test write verify done");
    give_verdict;
  end
endmodule

// >>> tb/media_model.sv
// Purpose: media engine stand-in answering write, verify and seek pulses
// Assumes: design pulses are one cycle wide, sampled at the falling edge
// Notes: i_slow stretches each operation; i_fail_at picks the verify that errs
`timescale 1ns/10ps
module media_model
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_write,
  input wire logic i_verify,
  input wire logic i_seek,
  input wire logic i_slow,
  input wire logic [7:0] i_fail_at,
  output logic o_done,
  output logic o_err,
  output logic [7:0] o_nverify
);
  int cnt;
  logic is_ver;
  initial
  begin
    o_done = 0;
    o_err = 0;
    o_nverify = 0;
    cnt = 0;
    is_ver = 0;
  end
  always @(negedge i_ref_clk)
  begin
    o_done <= 0;
    // error line means nothing without done, so it is kept moving
    o_err <= ~o_err;
    if (i_rst)
    begin
      cnt <= 0;
      o_nverify <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      cnt <= 0;
      o_done <= 1;
      o_err <= is_ver && i_fail_at != 0 && o_nverify == i_fail_at;
    end
    else if (i_write || i_verify || i_seek)
    begin
      cnt <= i_slow ? 20 : 1;
      is_ver <= i_verify;
      if (i_verify)
        o_nverify <= o_nverify + 1;
    end
  end
endmodule

// >>> verilog/disk_cmd_consts.svh
// Purpose: constants for the disk command interpreter
// Assumes: eight-bit task-file registers at 0x1f1..0x1f7
// Notes: definitions only
`ifndef DISK_CMD_CONSTS_SVH
`define DISK_CMD_CONSTS_SVH
`define ADDR_FEATURES_ERROR 10'h1f1
`define ADDR_SECTOR_COUNT 10'h1f2
`define ADDR_SECTOR_NUMBER 10'h1f3
`define ADDR_CYLINDER_LOW 10'h1f4
`define ADDR_CYLINDER_HIGH 10'h1f5
`define ADDR_DEVICE_HEAD 10'h1f6
`define ADDR_COMMAND_STATUS 10'h1f7
`define OP_WRITE_VERIFY 8'h3c
`define OP_SET_GEOMETRY 8'h91
`define NIB_RECAL 4'h1
`define NIB_SEEK 4'h7
`define ST_BSY 7
`define ST_DRDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_ABRT 2
`define ER_UNC 6
`define DH_LBA 6
`define RST_GEOM_SPT 8'h3f
`define RST_GEOM_MAXHEAD 4'hf
`endif

// >>> verilog/disk_cmd_pkg.sv
// Purpose: types for the disk command interpreter
// Assumes: nothing
// Notes: states only
package disk_cmd_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_RECAL, S_SEEK, S_GEOM, S_WV_DATA, S_WV_WRITE, S_WV_VERIFY, S_DONE
  } state_type;
endpackage

// >>> verilog/disk_seek_verify_param_cmds.sv
// Purpose: command execution for write-verify, recalibrate, seek, set-geometry
// Assumes: host bus synchronous to i_ref_clk; media engine outside answers done pulses
// Notes: one write strobe or one read strobe per cycle
// Functional notes
// - Write-verify 0x3c writes each sector and verifies it before the next one.
// - Verify reads the sector back without host transfer and reports any error.
// - On a write-verify error the sector count holds the sectors not transferred.
// - Any 0x1x command sets busy and rezeroes the heads to track zero.
// - Rezero end updates status, drops busy and raises an interrupt.
// - Recalibrate is accepted while logical addressing is selected.
// - In cylinder-head-sector mode any 0x7x command seeks to the cylinder registers and selects the head field.
// - Seek completion clears busy and raises an interrupt.
// - Seek-complete status bit always reads one.
// - In logical mode seek converts the block address into cylinder and head.
// - Host gives sectors per track in sector count and max head in the head field.
// - Set-geometry sets busy, stores both values, clears busy and interrupts.
// - Set-geometry with zero sector count ends with an aborted-command error.
// - Stored geometry survives resets.
// - Set-geometry ignores the addressing-mode bit and acts as cylinder-head-sector.
`timescale 1ns/10ps
`include "disk_cmd_consts.svh"
module disk_seek_verify_param_cmds
#(
  parameter int SEEK_CYCLES = 16
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [9:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_intrq,
  output logic o_drq,
  output logic o_media_write,
  output logic o_media_verify,
  output logic o_media_seek,
  output logic [15:0] o_seek_cyl,
  output logic [3:0] o_seek_head,
  output logic [7:0] o_geom_spt,
  output logic [3:0] o_geom_maxhead,
  input wire logic i_media_done,
  input wire logic i_media_err,
  input wire logic i_data_valid
);
  import disk_cmd_pkg::*;
  state_type state_q, state_d;
  logic [7:0] fr_q, fr_d, er_q, er_d, sc_q, sc_d, sn_q, sn_d, cl_q, cl_d, ch_q, ch_d;
  logic [7:0] dh_q, dh_d, st_q, st_d, rdata_q, rdata_d;
  logic [7:0] spt_q, spt_d;
  logic [3:0] maxh_q, maxh_d, head_q, head_d;
  logic [15:0] cyl_q, cyl_d;
  logic intrq_q, intrq_d, drq_q, drq_d, mw_q, mw_d, mv_q, mv_d, ms_q, ms_d;
  logic geom_valid_q, geom_valid_d;
  logic [27:0] lba;
  logic [27:0] trk;
  logic [7:0] sec_idx;
  logic [3:0] hd_idx;
  logic cmd_wr;

  assign cmd_wr = i_wr && (i_addr == `ADDR_COMMAND_STATUS);
  assign lba = {dh_q[3:0], ch_q, cl_q, sn_q};
  // division kept combinational; geometry is small and rarely changes
  assign trk = (spt_q == 8'h00) ? 28'h0 : lba / {20'h0, spt_q};
  assign sec_idx = 8'h0;
  assign hd_idx = 4'h0;

  always_comb
  begin
    logic [27:0] cyl_w;
    logic [27:0] hd_w;
    cyl_w = 28'h0;
    hd_w = 28'h0;
    state_d = state_q;
    fr_d = fr_q; er_d = er_q; sc_d = sc_q; sn_d = sn_q; cl_d = cl_q; ch_d = ch_q;
    dh_d = dh_q; st_d = st_q; spt_d = spt_q; maxh_d = maxh_q;
    cyl_d = cyl_q; head_d = head_q;
    // marker rises on the first clock after power-up and then never drops
    geom_valid_d = 1'b1;
    intrq_d = intrq_q; drq_d = 1'b0; mw_d = 1'b0; mv_d = 1'b0; ms_d = 1'b0;
    st_d[`ST_DSC] = 1'b1;
    rdata_d = 8'h00;
    // reads of status clear the interrupt, as on any task file
    if (i_rd)
    begin
      case (i_addr)
        `ADDR_FEATURES_ERROR: rdata_d = er_q;
        `ADDR_SECTOR_COUNT: rdata_d = sc_q;
        `ADDR_SECTOR_NUMBER: rdata_d = sn_q;
        `ADDR_CYLINDER_LOW: rdata_d = cl_q;
        `ADDR_CYLINDER_HIGH: rdata_d = ch_q;
        `ADDR_DEVICE_HEAD: rdata_d = dh_q;
        `ADDR_COMMAND_STATUS:
        begin
          rdata_d = st_q;
          intrq_d = 1'b0;
        end
        default: rdata_d = 8'h00;
      endcase
    end
    // parameter writes while busy are ignored
    if (i_wr && !st_q[`ST_BSY])
    begin
      case (i_addr)
        `ADDR_FEATURES_ERROR: fr_d = i_wdata;
        `ADDR_SECTOR_COUNT: sc_d = i_wdata;
        `ADDR_SECTOR_NUMBER: sn_d = i_wdata;
        `ADDR_CYLINDER_LOW: cl_d = i_wdata;
        `ADDR_CYLINDER_HIGH: ch_d = i_wdata;
        `ADDR_DEVICE_HEAD: dh_d = i_wdata;
        default: ;
      endcase
    end
    case (state_q)
      S_IDLE:
      begin
        if (cmd_wr && !st_q[`ST_BSY])
        begin
          er_d = 8'h00;
          st_d[`ST_ERR] = 1'b0;
          intrq_d = 1'b0;
          if (i_wdata[7:4] == `NIB_RECAL)
          begin
            st_d[`ST_BSY] = 1'b1;
            cyl_d = 16'h0;
            ms_d = 1'b1;
            state_d = S_RECAL;
          end
          else if (i_wdata[7:4] == `NIB_SEEK)
          begin
            st_d[`ST_BSY] = 1'b1;
            if (dh_q[`DH_LBA])
            begin
              hd_w = (maxh_q == 4'h0) ? 28'h0 : trk % ({24'h0, maxh_q} + 28'h1);
              cyl_w = trk / ({24'h0, maxh_q} + 28'h1);
              cyl_d = cyl_w[15:0];
              head_d = hd_w[3:0];
            end
            else
            begin
              cyl_d = {ch_q, cl_q};
              head_d = dh_q[3:0];
            end
            ms_d = 1'b1;
            state_d = S_SEEK;
          end
          else if (i_wdata == `OP_SET_GEOMETRY)
          begin
            st_d[`ST_BSY] = 1'b1;
            state_d = S_GEOM;
          end
          else if (i_wdata == `OP_WRITE_VERIFY)
          begin
            st_d[`ST_BSY] = 1'b0;
            st_d[`ST_DRQ] = 1'b1;
            state_d = S_WV_DATA;
          end
          else
          begin
            er_d[`ER_ABRT] = 1'b1;
            st_d[`ST_ERR] = 1'b1;
            intrq_d = 1'b1;
          end
        end
      end
      S_RECAL, S_SEEK:
      begin
        if (i_media_done)
        begin
          st_d[`ST_BSY] = 1'b0;
          st_d[`ST_DRDY] = 1'b1;
          if (i_media_err)
          begin
            st_d[`ST_ERR] = 1'b1;
            er_d[`ER_ABRT] = 1'b1;
          end
          intrq_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_GEOM:
      begin
        if (sc_q == 8'h00)
        begin
          st_d[`ST_ERR] = 1'b1;
          er_d[`ER_ABRT] = 1'b1;
        end
        else
        begin
          spt_d = sc_q;
          maxh_d = dh_q[3:0];
        end
        st_d[`ST_BSY] = 1'b0;
        intrq_d = 1'b1;
        state_d = S_IDLE;
      end
      S_WV_DATA:
      begin
        st_d[`ST_DRQ] = 1'b1;
        // drop the request as the sector is taken; the next sector is asked for only after this one verifies
        drq_d = !i_data_valid;
        if (i_data_valid)
        begin
          st_d[`ST_DRQ] = 1'b0;
          st_d[`ST_BSY] = 1'b1;
          mw_d = 1'b1;
          state_d = S_WV_WRITE;
        end
      end
      S_WV_WRITE:
      begin
        if (i_media_done)
        begin
          if (i_media_err)
          begin
            er_d[`ER_UNC] = 1'b1;
            state_d = S_DONE;
          end
          else
          begin
            mv_d = 1'b1;
            state_d = S_WV_VERIFY;
          end
        end
      end
      S_WV_VERIFY:
      begin
        if (i_media_done)
        begin
          if (i_media_err)
          begin
            er_d[`ER_UNC] = 1'b1;
            state_d = S_DONE;
          end
          else
          begin
            sc_d = sc_q - 8'h01;
            sn_d = sn_q + 8'h01;
            if (sc_q == 8'h01)
            begin
              state_d = S_DONE;
            end
            else
            begin
              st_d[`ST_BSY] = 1'b0;
              st_d[`ST_DRQ] = 1'b1;
              state_d = S_WV_DATA;
            end
          end
        end
      end
      S_DONE:
      begin
        // sc_q already counts only untransferred sectors on error
        st_d[`ST_ERR] = er_q[`ER_UNC];
        st_d[`ST_BSY] = 1'b0;
        st_d[`ST_DRQ] = 1'b0;
        intrq_d = 1'b1;
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_q <= S_IDLE;
      fr_q <= 8'h00; er_q <= 8'h00; sc_q <= 8'h01; sn_q <= 8'h01;
      cl_q <= 8'h00; ch_q <= 8'h00; dh_q <= 8'h00;
      st_q <= 8'h50;
      cyl_q <= 16'h0; head_q <= 4'h0;
      intrq_q <= 1'b0; drq_q <= 1'b0; mw_q <= 1'b0; mv_q <= 1'b0; ms_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      fr_q <= fr_d; er_q <= er_d; sc_q <= sc_d; sn_q <= sn_d;
      cl_q <= cl_d; ch_q <= ch_d; dh_q <= dh_d; st_q <= st_d;
      cyl_q <= cyl_d; head_q <= head_d;
      intrq_q <= intrq_d; drq_q <= drq_d; mw_q <= mw_d; mv_q <= mv_d; ms_q <= ms_d;
      rdata_q <= rdata_d;
    end
  end

  // geometry kept out of reset so it survives drive resets
  always_ff @(posedge i_ref_clk)
  begin
    if (geom_valid_q)
    begin
      spt_q <= spt_d;
      maxh_q <= maxh_d;
    end
    else
    begin
      // power-up defaults, loaded once; an unknown marker also lands here
      spt_q <= `RST_GEOM_SPT;
      maxh_q <= `RST_GEOM_MAXHEAD;
    end
    geom_valid_q <= geom_valid_d;
  end

  assign o_rdata = rdata_q;
  assign o_intrq = intrq_q;
  assign o_drq = drq_q;
  assign o_media_write = mw_q;
  assign o_media_verify = mv_q;
  assign o_media_seek = ms_q;
  assign o_seek_cyl = cyl_q;
  assign o_seek_head = head_q;
  assign o_geom_spt = spt_q;
  assign o_geom_maxhead = maxh_q;

  property p_dsc_one;
    @(posedge i_ref_clk) disable iff (i_rst) ##1 st_q[`ST_DSC];
  endproperty
  a_dsc_one: assert property (p_dsc_one) else $error("dsc not one");

  property p_recal_busy;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == S_IDLE && cmd_wr && !st_q[`ST_BSY] && i_wdata[7:4] == `NIB_RECAL)
      |=> st_q[`ST_BSY] && cyl_q == 16'h0 && ms_q;
  endproperty
  a_recal_busy: assert property (p_recal_busy) else $error("recal start");

  sequence s_move_done;
    (state_q == S_RECAL || state_q == S_SEEK) && i_media_done;
  endsequence
  property p_move_end;
    @(posedge i_ref_clk) disable iff (i_rst) s_move_done |=> !st_q[`ST_BSY] && intrq_q;
  endproperty
  a_move_end: assert property (p_move_end) else $error("move end");

  property p_seek_chs;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == S_IDLE && cmd_wr && !st_q[`ST_BSY] && i_wdata[7:4] == `NIB_SEEK
       && !dh_q[`DH_LBA]) |=> cyl_q == $past({ch_q, cl_q}) && head_q == $past(dh_q[3:0]);
  endproperty
  a_seek_chs: assert property (p_seek_chs) else $error("seek target");

  property p_geom_abort;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == S_GEOM && sc_q == 8'h00) |=> er_q[`ER_ABRT] && st_q[`ST_ERR] && intrq_q;
  endproperty
  a_geom_abort: assert property (p_geom_abort) else $error("geom abort");

  property p_geom_store;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == S_GEOM && sc_q != 8'h00) |=> spt_q == $past(sc_q) && !st_q[`ST_BSY];
  endproperty
  a_geom_store: assert property (p_geom_store) else $error("geom store");

  property p_verify_after_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == S_WV_WRITE && i_media_done && !i_media_err) |=> mv_q;
  endproperty
  a_verify_after_write: assert property (p_verify_after_write) else $error("no verify");

  property p_verify_err;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == S_WV_VERIFY && i_media_done && i_media_err) |=> ##1 st_q[`ST_ERR] && intrq_q;
  endproperty
  a_verify_err: assert property (p_verify_err) else $error("verify err");

  property p_geom_keep;
    @(posedge i_ref_clk) (geom_valid_q && i_rst) |=> spt_q == $past(spt_q);
  endproperty
  a_geom_keep: assert property (p_geom_keep) else $error("geom lost");
endmodule
